// *** common/sleep_wake_watchdog_defines.svh ***
// Purpose: Offsets, bit positions, reset values and timing of the sleep/watchdog block
// Assumes: 20 MHz core clock
// Notes:   Definitions only
`ifndef SLEEP_WAKE_WATCHDOG_DEFINES_SVH
`define SLEEP_WAKE_WATCHDOG_DEFINES_SVH

// Register byte offsets
`define OFS_INTERRUPT_CONTROL   8'h00
`define OFS_PIN_CHANGE_MASK_A   8'h04
`define OFS_PIN_CHANGE_MASK_B   8'h08
`define OFS_PERIPH_IRQ_ENABLE_1 8'h0C
`define OFS_PERIPH_IRQ_ENABLE_2 8'h10
`define OFS_PERIPH_IRQ_FLAG_1   8'h14
`define OFS_PERIPH_IRQ_FLAG_2   8'h18
`define OFS_CPU_STATUS          8'h1C
`define OFS_TIMER_OPTION        8'h20
`define OFS_FUSE_WORD           8'h24

// Implemented-bit masks
`define MASK_PIN_CHANGE_A       8'hEF
`define MASK_PIN_CHANGE_B       8'hF3
`define MASK_PERIPH_1           8'h7F
`define MASK_PERIPH_2           8'h9F
`define MASK_INTERRUPT_CONTROL_FLAGS       8'h07

// Field positions
`define BIT_GLOBAL_IRQ_ENABLE   7
`define BIT_PERIPH_IRQ_ENABLE   6
`define BIT_TIMER_IRQ_ENABLE    5
`define BIT_EXT_IRQ_ENABLE      4
`define BIT_PIN_CHANGE_ENABLE   3
`define BIT_TIMER_IRQ_FLAG      2
`define BIT_EXT_IRQ_FLAG        1
`define BIT_PIN_CHANGE_FLAG     0
`define BIT_TIMEOUT_FLAG        4
`define BIT_POWER_DOWN_FLAG     3
`define BIT_PRESCALER_ASSIGN    3
`define BIT_WATCHDOG_FUSE_EN    3
`define BIT_EXT_RESET_PIN_EN    5

// Reset values
`define RST_INTERRUPT_CONTROL   8'h00
`define RST_MASK                8'h00
`define RST_CPU_STATUS          8'h18
`define RST_TIMER_OPTION        8'hFF
`define RST_FUSE_WORD           14'h3FFF

// Timing
`define CORE_CLK_PERIOD_NS      50
`define WDT_PERIOD_MS           18
`define WDT_PERIOD_CYCLES       ((`WDT_PERIOD_MS * 1000000) / `CORE_CLK_PERIOD_NS)

`endif

// *** common/sleep_wake_pkg.sv ***
// Purpose: Types of the sleep/wake/watchdog block
// Assumes: APB with 32-bit data
// Notes:   Constants live in the defines header
package sleep_wake_pkg;

  typedef enum logic {
    RUN,
    ASLEEP
  } power_state_type;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    power_state_type power;
    logic [7:0]      interrupt_control;
    logic [7:0]      pin_change_mask_a;
    logic [7:0]      pin_change_mask_b;
    logic [7:0]      periph_irq_enable_1;
    logic [7:0]      periph_irq_enable_2;
    logic [7:0]      periph_irq_flag_1;
    logic [7:0]      periph_irq_flag_2;
    logic [7:0]      cpu_status;
    logic [7:0]      timer_option;
    logic [13:0]     fuse_word;
    logic            fuse_loaded;
    logic [23:0]     watchdog_count;
    logic [7:0]      prescaler;
    logic [15:0]     pin_prev;
    logic            device_reset;
    logic            resume;
    logic            resume_to_isr;
    logic            prefetch;
    logic            timer_prescaled;
    logic [31:0]     prdata;
  } state_type;

endpackage : sleep_wake_pkg

// *** rtl/sleep_wake_watchdog.sv ***
// Purpose: Sleep control, wake arbitration and watchdog timer with shared prescaler
// Assumes: Core pulses one instruction strobe per cycle; inputs synchronous to CORE_CLK_I
// Notes:   Watchdog runs on the core clock here; its period is a parameter
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_watchdog_defines.svh"

// Behaviour
// - Sleep entry clears watchdog counter; enabled watchdog keeps counting while asleep.
// - Sleep entry clears power-down flag and sets timeout flag.
// - CPU clock is stopped while asleep.
// - I/O ports hold their pre-sleep state while asleep.
// - Analog supply rail is off while asleep.
// - Sleep leaves other resets and analog enable settings untouched.
// - Power-on reset event while asleep wakes the device.
// - Reset pin and POR wake with reset; watchdog and interrupts wake and resume.
// - Pin-change and external pin interrupts can wake the device.
// - Interrupt wake needs its own enable, regardless of global enable.
// - Sleep prefetches next instruction; it executes first after wake.
// - After interrupt wake, vector to service routine only if global enable set.
// - Every wake from sleep clears the watchdog counter.
// - Sleep with an enabled pending interrupt acts as no-operation, flags untouched.
// - Interrupt during or after sleep: sleep completes, then immediate wake.
// - Watchdog runs only while its fuse enable bit is set.
// - Watchdog timeout resets when running, wakes and resumes when asleep.
// - Base period 18 ms; prescaler up to 1:128 for the watchdog.
// - Prescaler assignment and ratio writable at any time.
// - Clear and sleep instructions clear counter and prescaler if assigned.
// - Watchdog timeout clears the timeout flag.
// - Interrupt flags set on their events regardless of enables.
module sleep_wake_watchdog #(
  parameter int unsigned WDT_PERIOD_CYCLES = `WDT_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic                       CORE_CLK_I,
  input  wire logic                       RESET_N_I,
  // Register bus
  input  wire sleep_wake_pkg::apb_req_type APB_REQ_I,
  output var  sleep_wake_pkg::apb_rsp_type APB_RSP_O,
  // Core instruction strobes
  input  wire logic                       SLEEP_INSTR_I,
  input  wire logic                       WATCHDOG_CLEAR_INSTR_I,
  // Wake and interrupt events
  input  wire logic                       EXTERNAL_RESET_PIN_N_I,
  input  wire logic                       POR_EVENT_I,
  input  wire logic                       EXT_IRQ_EVENT_I,
  input  wire logic [15:0]                PIN_LEVEL_I,
  input  wire logic                       TIMER_OVERFLOW_I,
  input  wire logic [7:0]                 PERIPH_EVENT_1_I,
  input  wire logic [7:0]                 PERIPH_EVENT_2_I,
  // Timer tick and fuses
  input  wire logic                       TIMER_TICK_I,
  input  wire logic [13:0]                FUSE_WORD_I,
  // Power and core control
  output logic                            CPU_CLK_EN_O,
  output logic                            ANALOG_SUPPLY_EN_O,
  output logic                            IO_HOLD_O,
  output logic                            PREFETCH_NEXT_O,
  output logic                            RESUME_O,
  output logic                            RESUME_TO_ISR_O,
  output logic                            DEVICE_RESET_O,
  output logic                            TIMER_PRESCALED_O
);

  sleep_wake_pkg::state_type st;
  sleep_wake_pkg::state_type next_st;

  logic        asleep;
  logic        watchdog_run;
  logic        base_tick;
  logic        wdt_timeout;
  logic        assigned_wdt;
  logic [7:0]  wdt_ratio_mask;
  logic [7:0]  timer_ratio_mask;
  logic        irq_pending;
  logic        irq_wake;
  logic        reset_wake;
  logic        sleep_enter;
  logic        sleep_nop;
  logic [15:0] pin_changed;
  logic        setup_phase;
  logic        access_wr;
  logic        addr_hit;
  logic [7:0]  offset;
  logic [7:0]  wdata;

  assign asleep       = (st.power == sleep_wake_pkg::ASLEEP);
  assign assigned_wdt = st.timer_option[`BIT_PRESCALER_ASSIGN];
  // Gated until the fuse word is captured after reset release
  assign watchdog_run = st.fuse_loaded & st.fuse_word[`BIT_WATCHDOG_FUSE_EN];
  assign base_tick    = watchdog_run & (st.watchdog_count == 24'(WDT_PERIOD_CYCLES - 1));
  // Ratio 1:1 to 1:128 for the watchdog, 1:2 to 1:256 for the timer
  assign wdt_ratio_mask   = (8'h01 << st.timer_option[2:0]) - 8'h01;
  assign timer_ratio_mask = {wdt_ratio_mask[6:0], 1'b1};
  assign wdt_timeout = base_tick & (!assigned_wdt | (st.prescaler == wdt_ratio_mask));

  assign irq_pending =
    (st.interrupt_control[`BIT_TIMER_IRQ_ENABLE]  & st.interrupt_control[`BIT_TIMER_IRQ_FLAG]) |
    (st.interrupt_control[`BIT_EXT_IRQ_ENABLE]    & st.interrupt_control[`BIT_EXT_IRQ_FLAG])   |
    (st.interrupt_control[`BIT_PIN_CHANGE_ENABLE] & st.interrupt_control[`BIT_PIN_CHANGE_FLAG]) |
    (st.interrupt_control[`BIT_PERIPH_IRQ_ENABLE] &
     (|(st.periph_irq_enable_1 & st.periph_irq_flag_1) |
      |(st.periph_irq_enable_2 & st.periph_irq_flag_2)));
  // Only the two sleep-capable sources wake; global enable is ignored here
  assign irq_wake =
    (st.interrupt_control[`BIT_EXT_IRQ_ENABLE]    & st.interrupt_control[`BIT_EXT_IRQ_FLAG]) |
    (st.interrupt_control[`BIT_PIN_CHANGE_ENABLE] & st.interrupt_control[`BIT_PIN_CHANGE_FLAG]);
  assign reset_wake = POR_EVENT_I |
                      (!EXTERNAL_RESET_PIN_N_I & st.fuse_word[`BIT_EXT_RESET_PIN_EN]);
  // Flags are registered, so an event in the sleep cycle itself lets sleep complete
  assign sleep_enter = SLEEP_INSTR_I & !asleep & !irq_pending;
  assign sleep_nop   = SLEEP_INSTR_I & !asleep & irq_pending;
  assign pin_changed = (PIN_LEVEL_I ^ st.pin_prev) &
                       {st.pin_change_mask_b & `MASK_PIN_CHANGE_B,
                        st.pin_change_mask_a & `MASK_PIN_CHANGE_A};

  assign setup_phase = APB_REQ_I.psel & !APB_REQ_I.penable;
  assign access_wr   = APB_REQ_I.psel & APB_REQ_I.penable & APB_REQ_I.pwrite;
  assign offset      = APB_REQ_I.paddr[7:0];
  assign wdata       = APB_REQ_I.pwdata[7:0];
  always_comb begin
    addr_hit = (APB_REQ_I.paddr[31:8] == 24'h00_0000) & (offset[1:0] == 2'b00) &
               (offset <= `OFS_FUSE_WORD);
  end

  always_comb begin
    next_st = st;
    next_st.device_reset    = 1'b0;
    next_st.resume          = 1'b0;
    next_st.prefetch        = 1'b0;
    next_st.timer_prescaled = 1'b0;
    next_st.pin_prev        = PIN_LEVEL_I;
    if (!st.fuse_loaded) begin
      next_st.fuse_word   = FUSE_WORD_I;
      next_st.fuse_loaded = 1'b1;
    end

    // Register writes; hardware sets below win over a clear in the same cycle
    if (access_wr & addr_hit) begin
      case (offset)
        `OFS_INTERRUPT_CONTROL:   next_st.interrupt_control   = wdata;
        `OFS_PIN_CHANGE_MASK_A:   next_st.pin_change_mask_a   = wdata & `MASK_PIN_CHANGE_A;
        `OFS_PIN_CHANGE_MASK_B:   next_st.pin_change_mask_b   = wdata & `MASK_PIN_CHANGE_B;
        `OFS_PERIPH_IRQ_ENABLE_1: next_st.periph_irq_enable_1 = wdata & `MASK_PERIPH_1;
        `OFS_PERIPH_IRQ_ENABLE_2: next_st.periph_irq_enable_2 = wdata & `MASK_PERIPH_2;
        `OFS_PERIPH_IRQ_FLAG_1:   next_st.periph_irq_flag_1   = wdata & `MASK_PERIPH_1;
        `OFS_PERIPH_IRQ_FLAG_2:   next_st.periph_irq_flag_2   = wdata & `MASK_PERIPH_2;
        // Timeout and power-down flags are hardware owned
        `OFS_CPU_STATUS: next_st.cpu_status = (wdata & 8'hE7) | (st.cpu_status & 8'h18);
        `OFS_TIMER_OPTION: next_st.timer_option = wdata;
        default: next_st.timer_option = next_st.timer_option;
      endcase
    end

    // Flags set whatever the enables
    next_st.interrupt_control[`BIT_TIMER_IRQ_FLAG] =
      next_st.interrupt_control[`BIT_TIMER_IRQ_FLAG] | TIMER_OVERFLOW_I;
    next_st.interrupt_control[`BIT_EXT_IRQ_FLAG] =
      next_st.interrupt_control[`BIT_EXT_IRQ_FLAG] | EXT_IRQ_EVENT_I;
    next_st.interrupt_control[`BIT_PIN_CHANGE_FLAG] =
      next_st.interrupt_control[`BIT_PIN_CHANGE_FLAG] | (|pin_changed);
    next_st.periph_irq_flag_1 = next_st.periph_irq_flag_1 | (PERIPH_EVENT_1_I & `MASK_PERIPH_1);
    next_st.periph_irq_flag_2 = next_st.periph_irq_flag_2 | (PERIPH_EVENT_2_I & `MASK_PERIPH_2);

    // Watchdog base counter and shared prescaler, counting awake or asleep
    if (!watchdog_run) begin
      next_st.watchdog_count = 24'h00_0000;
    end else if (base_tick) begin
      next_st.watchdog_count = 24'h00_0000;
    end else begin
      next_st.watchdog_count = st.watchdog_count + 24'h00_0001;
    end
    if (assigned_wdt) begin
      if (base_tick) begin
        next_st.prescaler = (st.prescaler == wdt_ratio_mask) ? 8'h00 : st.prescaler + 8'h01;
      end
      next_st.timer_prescaled = TIMER_TICK_I;
    end else if (TIMER_TICK_I) begin
      next_st.prescaler       = (st.prescaler == timer_ratio_mask) ? 8'h00 : st.prescaler + 8'h01;
      next_st.timer_prescaled = (st.prescaler == timer_ratio_mask);
    end

    if (wdt_timeout) begin
      next_st.cpu_status[`BIT_TIMEOUT_FLAG] = 1'b0;
    end

    // Other reset sources act the same awake or asleep
    if (reset_wake) begin
      next_st.device_reset = 1'b1;
    end

    case (st.power)
      sleep_wake_pkg::RUN: begin
        if (wdt_timeout) begin
          next_st.device_reset = 1'b1;
        end else if (sleep_enter) begin
          next_st.power          = sleep_wake_pkg::ASLEEP;
          next_st.watchdog_count = 24'h00_0000;
          if (assigned_wdt) begin
            next_st.prescaler = 8'h00;
          end
          next_st.cpu_status[`BIT_POWER_DOWN_FLAG] = 1'b0;
          next_st.cpu_status[`BIT_TIMEOUT_FLAG]    = 1'b1;
          next_st.prefetch = 1'b1;
        end else if (WATCHDOG_CLEAR_INSTR_I) begin
          next_st.watchdog_count = 24'h00_0000;
          if (assigned_wdt) begin
            next_st.prescaler = 8'h00;
          end
        end
      end
      sleep_wake_pkg::ASLEEP: begin
        if (reset_wake | wdt_timeout | irq_wake) begin
          next_st.power          = sleep_wake_pkg::RUN;
          next_st.watchdog_count = 24'h00_0000;
          if (assigned_wdt) begin
            next_st.prescaler = 8'h00;
          end
          // Resume runs the prefetched instruction, then vectors if enabled
          next_st.resume        = !reset_wake;
          next_st.resume_to_isr = !reset_wake & !wdt_timeout &
                                  st.interrupt_control[`BIT_GLOBAL_IRQ_ENABLE];
        end
      end
      default: next_st.power = sleep_wake_pkg::RUN;
    endcase

    // Read data captured in the setup phase so the access phase needs no wait
    if (setup_phase) begin
      next_st.prdata = 32'h0000_0000;
      case (offset)
        `OFS_INTERRUPT_CONTROL:   next_st.prdata[7:0] = st.interrupt_control;
        `OFS_PIN_CHANGE_MASK_A:   next_st.prdata[7:0] = st.pin_change_mask_a;
        `OFS_PIN_CHANGE_MASK_B:   next_st.prdata[7:0] = st.pin_change_mask_b;
        `OFS_PERIPH_IRQ_ENABLE_1: next_st.prdata[7:0] = st.periph_irq_enable_1;
        `OFS_PERIPH_IRQ_ENABLE_2: next_st.prdata[7:0] = st.periph_irq_enable_2;
        `OFS_PERIPH_IRQ_FLAG_1:   next_st.prdata[7:0] = st.periph_irq_flag_1;
        `OFS_PERIPH_IRQ_FLAG_2:   next_st.prdata[7:0] = st.periph_irq_flag_2;
        `OFS_CPU_STATUS:          next_st.prdata[7:0] = st.cpu_status;
        `OFS_TIMER_OPTION:        next_st.prdata[7:0] = st.timer_option;
        `OFS_FUSE_WORD:           next_st.prdata[13:0] = st.fuse_word;
        default:                  next_st.prdata = 32'h0000_0000;
      endcase
      if (!addr_hit) begin
        next_st.prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RESET_N_I) begin
      st.power               <= sleep_wake_pkg::RUN;
      st.interrupt_control   <= `RST_INTERRUPT_CONTROL;
      st.pin_change_mask_a   <= `RST_MASK;
      st.pin_change_mask_b   <= `RST_MASK;
      st.periph_irq_enable_1 <= `RST_MASK;
      st.periph_irq_enable_2 <= `RST_MASK;
      st.periph_irq_flag_1   <= `RST_MASK;
      st.periph_irq_flag_2   <= `RST_MASK;
      st.cpu_status          <= `RST_CPU_STATUS;
      st.timer_option        <= `RST_TIMER_OPTION;
      st.fuse_word           <= `RST_FUSE_WORD;
      st.fuse_loaded         <= 1'b0;
      st.watchdog_count      <= 24'h00_0000;
      st.prescaler           <= 8'h00;
      st.pin_prev            <= 16'h0000;
      st.device_reset        <= 1'b0;
      st.resume              <= 1'b0;
      st.resume_to_isr       <= 1'b0;
      st.prefetch            <= 1'b0;
      st.timer_prescaled     <= 1'b0;
      st.prdata              <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Rail is gated, stored analog enables are never touched
  assign CPU_CLK_EN_O       = !asleep;
  assign ANALOG_SUPPLY_EN_O = !asleep;
  assign IO_HOLD_O          = asleep;
  assign PREFETCH_NEXT_O    = st.prefetch;
  assign RESUME_O           = st.resume;
  assign RESUME_TO_ISR_O    = st.resume_to_isr;
  assign DEVICE_RESET_O     = st.device_reset;
  assign TIMER_PRESCALED_O  = st.timer_prescaled;
  assign APB_RSP_O.prdata   = st.prdata;
  assign APB_RSP_O.pready   = 1'b1;
  assign APB_RSP_O.pslverr  = APB_REQ_I.psel & APB_REQ_I.penable & !addr_hit;

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);

  a_sleep_flags: assert property (sleep_enter & !wdt_timeout |=> asleep &&
    st.cpu_status[`BIT_POWER_DOWN_FLAG] == 1'b0 && st.cpu_status[`BIT_TIMEOUT_FLAG] == 1'b1)
    else $error("sleep entry flags wrong");
  a_sleep_nop: assert property (sleep_nop |=> !asleep &&
    st.cpu_status[`BIT_POWER_DOWN_FLAG] == $past(st.cpu_status[`BIT_POWER_DOWN_FLAG]) &&
    (!st.cpu_status[`BIT_TIMEOUT_FLAG] || $past(st.cpu_status[`BIT_TIMEOUT_FLAG])))
    else $error("sleep with pending irq not a nop");
  // Rail stays off while asleep; clock comes back only through a wake source, never on its own
  a_clock_gated: assert property (asleep |-> !CPU_CLK_EN_O && !ANALOG_SUPPLY_EN_O ##1
    (!CPU_CLK_EN_O || $past(reset_wake | wdt_timeout | irq_wake)))
    else $error("clock or rail on while asleep");
  a_io_hold: assert property (IO_HOLD_O == asleep &&
    (!$rose(IO_HOLD_O) || $past(SLEEP_INSTR_I & !irq_pending)))
    else $error("io hold mismatch");
  a_sleep_clears_wdt: assert property (sleep_enter & !wdt_timeout |=>
    st.watchdog_count == 0)
    else $error("watchdog not cleared on sleep");
  a_clear_instr: assert property (WATCHDOG_CLEAR_INSTR_I & !asleep & !SLEEP_INSTR_I &
    !wdt_timeout |=> st.watchdog_count == 0 && (st.prescaler == 0 || !$past(assigned_wdt)))
    else $error("clear instruction missed");
  a_wake_clears_wdt: assert property (asleep & (reset_wake | wdt_timeout | irq_wake) |=>
    st.watchdog_count == 0)
    else $error("watchdog not cleared on wake");
  a_irq_wake: assert property (asleep & irq_wake & !reset_wake & !wdt_timeout |=>
    !asleep && RESUME_O && RESUME_TO_ISR_O == $past(st.interrupt_control[7]))
    else $error("interrupt wake wrong");
  a_por_wake: assert property (asleep & POR_EVENT_I |=>
    !asleep && DEVICE_RESET_O && !RESUME_O)
    else $error("por did not wake with reset");
  a_wdt_reset: assert property (!asleep & wdt_timeout |=> DEVICE_RESET_O &&
    st.cpu_status[`BIT_TIMEOUT_FLAG] == 1'b0)
    else $error("timeout did not reset");
  a_fuse_off: assert property (st.fuse_loaded & !st.fuse_word[`BIT_WATCHDOG_FUSE_EN] |->
    st.watchdog_count == 0 && !wdt_timeout)
    else $error("watchdog ran while fused off");
  a_flag_set: assert property (EXT_IRQ_EVENT_I |=>
    st.interrupt_control[`BIT_EXT_IRQ_FLAG])
    else $error("ext irq flag not set");

  c_sleep_entered: cover property (sleep_enter);
  c_sleep_nop:     cover property (sleep_nop);
  c_irq_wake:      cover property (asleep & irq_wake ##1 RESUME_O);
  c_wdt_wake:      cover property (asleep & wdt_timeout ##1 RESUME_O);
  c_por_wake:      cover property (asleep & POR_EVENT_I ##1 DEVICE_RESET_O);

endmodule : sleep_wake_watchdog
`default_nettype wire

// *** verification/core_model.sv ***
// Purpose: Processor core stand-in that issues sleep and watchdog-clear strobes
// Assumes: One-cycle strobes launched just after a rising edge
// Notes:   Stalls while its clock is gated, as a real core would
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock
  input  wire logic clk_i,
  // Clock gate from the block
  input  wire logic cpu_clk_en_i,
  // Instruction strobes
  output logic      sleep_instr_o,
  output logic      clear_instr_o
);
  initial begin
    sleep_instr_o = 1'b0;
    clear_instr_o = 1'b0;
  end

  // The slot after sleep is a no-operation, so nothing issues on wake
  task automatic exec(input logic is_sleep);
    @(posedge clk_i);
    while (cpu_clk_en_i !== 1'b1) @(posedge clk_i);
    sleep_instr_o <= is_sleep;
    clear_instr_o <= !is_sleep;
    @(posedge clk_i);
    sleep_instr_o <= 1'b0;
    clear_instr_o <= 1'b0;
  endtask : exec
endmodule : core_model
`default_nettype wire

// *** verification/sleep_wake_watchdog_test.sv ***
// Purpose: Self-checking bench for sleep, wake and watchdog
// Assumes: Short watchdog period so timeouts fit in a brief run
// Notes:   Each scenario resets the block, so the default watchdog never bites
`timescale 1ns/100ps
`default_nettype none
`include "sleep_wake_watchdog_defines.svh"
module sleep_wake_watchdog_test;
  localparam int WDT = 16;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        por = 1'b0;
  logic        pin_n = 1'b1;
  logic        ext_irq = 1'b0;
  logic [15:0] pins = 16'h0000;
  logic [13:0] fuse = 14'h3FFF;
  logic        tovf = 1'b0;
  logic        tick = 1'b0;
  logic [7:0]  pev1 = 8'h00;
  logic [7:0]  pev2 = 8'h00;
  logic        tpre;
  logic        sleep_s, clear_s, cpu_en, an_en, hold, pref, resume, to_isr, dev_rst;
  logic [31:0] rd;
  sleep_wake_pkg::apb_req_type req = '0;
  sleep_wake_pkg::apb_rsp_type rsp;
  int          n_mismatch = 0;
  int          n_tests = 0;

  always #25 clk = ~clk;

  sleep_wake_watchdog #(.WDT_PERIOD_CYCLES(WDT)) dut (
    .CORE_CLK_I(clk), .RESET_N_I(rst_n), .APB_REQ_I(req), .APB_RSP_O(rsp),
    .SLEEP_INSTR_I(sleep_s), .WATCHDOG_CLEAR_INSTR_I(clear_s),
    .EXTERNAL_RESET_PIN_N_I(pin_n), .POR_EVENT_I(por), .EXT_IRQ_EVENT_I(ext_irq),
    .PIN_LEVEL_I(pins), .TIMER_OVERFLOW_I(tovf), .PERIPH_EVENT_1_I(pev1),
    .PERIPH_EVENT_2_I(pev2), .TIMER_TICK_I(tick), .FUSE_WORD_I(fuse),
    .CPU_CLK_EN_O(cpu_en), .ANALOG_SUPPLY_EN_O(an_en), .IO_HOLD_O(hold),
    .PREFETCH_NEXT_O(pref), .RESUME_O(resume), .RESUME_TO_ISR_O(to_isr),
    .DEVICE_RESET_O(dev_rst), .TIMER_PRESCALED_O(tpre));

  core_model core (.clk_i(clk), .cpu_clk_en_i(cpu_en), .sleep_instr_o(sleep_s),
    .clear_instr_o(clear_s));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Waits on pready rather than assuming zero wait states
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    req <= '{paddr: {24'h00_0000, a}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: wd};
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (rsp.pready !== 1'b1) @(posedge clk);
    rd = rsp.prdata;
    chk(rsp.pslverr, a > 8'h24);
    req <= '0;
  endtask : apb

  task automatic do_reset(input logic [13:0] f);
    @(posedge clk);
    fuse <= f;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // Returns 60 when neither a resume nor a reset shows up
  task automatic wait_wake(output int n);
    for (n = 0; n < 60; n++) begin
      @(negedge clk);
      if (resume === 1'b1 || dev_rst === 1'b1) break;
    end
  endtask : wait_wake

  task automatic t_registers;
    do_reset(14'h3FFF);
    apb(1'b0, `OFS_CPU_STATUS, '0);
    chk(rd, {24'h00_0000, `RST_CPU_STATUS});
    apb(1'b0, `OFS_FUSE_WORD, '0);
    chk(rd, 32'h0000_3FFF);
    apb(1'b1, `OFS_TIMER_OPTION, 32'h0000_00F7);
    apb(1'b0, `OFS_TIMER_OPTION, '0);
    chk(rd, 32'h0000_00F7);
    apb(1'b0, 8'h28, '0);
    chk(rd, 32'h0000_0000);
    $display("registers done");
  endtask : t_registers

  task automatic t_sleep_nop;
    do_reset(14'h3FFF);
    apb(1'b1, `OFS_INTERRUPT_CONTROL, 32'h0000_0010);
    @(posedge clk) ext_irq <= 1'b1;
    @(posedge clk) ext_irq <= 1'b0;
    core.exec(1'b1);
    repeat (3) @(negedge clk);
    chk({cpu_en, hold}, 2'b10);
    apb(1'b0, `OFS_CPU_STATUS, '0);
    chk(rd[4:3], 2'b11);
    $display("sleep nop done");
  endtask : t_sleep_nop

  // Prescaler on the timer at 1:2, then a peripheral flag makes sleep a no-operation
  task automatic t_periph;
    int cnt = 0;
    do_reset(14'h3FFF);
    apb(1'b1, `OFS_TIMER_OPTION, 32'h0000_00F0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      tick <= (i < 4);
      cnt += (tpre === 1'b1);
    end
    chk(cnt, 2);
    apb(1'b1, `OFS_PERIPH_IRQ_ENABLE_1, 32'h0000_0001);
    apb(1'b1, `OFS_INTERRUPT_CONTROL, 32'h0000_0040);
    @(posedge clk);
    pev1 <= 8'h81;
    pev2 <= 8'hFF;
    tovf <= 1'b1;
    @(posedge clk);
    pev1 <= 8'h00;
    pev2 <= 8'h00;
    tovf <= 1'b0;
    apb(1'b0, `OFS_PERIPH_IRQ_FLAG_2, '0);
    chk(rd, 32'h0000_009F);
    apb(1'b0, `OFS_INTERRUPT_CONTROL, '0);
    chk(rd, 32'h0000_0044);
    core.exec(1'b1);
    @(negedge clk);
    chk({cpu_en, hold}, 2'b10);
    apb(1'b0, `OFS_PERIPH_IRQ_FLAG_1, '0);
    chk(rd, 32'h0000_0001);
    $display("peripheral and prescaler done");
  endtask : t_periph

  // Pass 0: external pin, global enable off; pass 1: pin change, global enable on
  task automatic t_irq_wake;
    int n;
    for (int k = 0; k < 2; k++) begin
      do_reset(14'h3FFF);
      apb(1'b1, `OFS_PIN_CHANGE_MASK_A, 32'h0000_0001);
      apb(1'b1, `OFS_INTERRUPT_CONTROL, k ? 32'h0000_0088 : 32'h0000_0010);
      core.exec(1'b1);
      @(negedge clk);
      chk({pref, cpu_en, an_en, hold}, 4'b1001);
      apb(1'b0, `OFS_CPU_STATUS, '0);
      chk(rd[4:3], 2'b10);
      @(posedge clk);
      if (k) pins <= ~pins;
      else ext_irq <= 1'b1;
      @(posedge clk) ext_irq <= 1'b0;
      wait_wake(n);
      chk(n < 5, 1'b1);
      chk({resume, to_isr, dev_rst, cpu_en}, {1'b1, k[0], 2'b01});
    end
    $display("interrupt wake done");
  endtask : t_irq_wake

  task automatic t_watchdog;
    int n;
    do_reset(14'h3FFF);
    apb(1'b1, `OFS_TIMER_OPTION, 32'h0000_00F7);
    core.exec(1'b1);
    wait_wake(n);
    chk({resume, dev_rst}, 2'b10);
    chk(n > WDT - 4 && n < WDT + 5, 1'b1);
    apb(1'b0, `OFS_CPU_STATUS, '0);
    chk(rd[4:3], 2'b00);
    wait_wake(n);
    chk({resume, dev_rst}, 2'b01);
    chk(n > 4 && n < WDT + 2, 1'b1);
    do_reset(14'h3FFF);
    apb(1'b1, `OFS_TIMER_OPTION, 32'h0000_00F7);
    repeat (8) @(posedge clk);
    core.exec(1'b0);
    wait_wake(n);
    chk(n > WDT - 4 && n < WDT + 5, 1'b1);
    $display("watchdog done");
  endtask : t_watchdog

  task automatic t_reset_wake;
    int n;
    for (int k = 0; k < 2; k++) begin
      do_reset(14'h3FFF);
      core.exec(1'b1);
      @(posedge clk);
      if (k) pin_n <= 1'b0;
      else por <= 1'b1;
      wait_wake(n);
      chk({dev_rst, resume, n < 4}, 3'b101);
      @(posedge clk);
      por <= 1'b0;
      pin_n <= 1'b1;
    end
    $display("reset wake done");
  endtask : t_reset_wake

  task automatic t_fuse_off;
    int n;
    do_reset(14'h3FF7);
    apb(1'b1, `OFS_TIMER_OPTION, 32'h0000_00F7);
    wait_wake(n);
    chk(n, 60);
    $display("fuse off done");
  endtask : t_fuse_off

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  initial begin
    t_registers;
    t_sleep_nop;
    t_periph;
    t_irq_wake;
    t_watchdog;
    t_reset_wake;
    t_fuse_off;
    final_report;
  end

  // The whole run needs well under a thousand cycles
  initial begin
    #(50 * 4000);
    n_mismatch++;
    final_report;
  end
endmodule : sleep_wake_watchdog_test
`default_nettype wire
